// *** dv/bfl_stage_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module bfl_stage_model (
  // Clock
  input wire logic clock_in,
  // Gate drives
  input wire logic high_side_drive_in,
  input wire logic low_side_drive_in,
  // Load behaviour
  input wire logic slow_in,
  input wire logic heavy_in,
  // Comparators
  output logic zero_cross_out,
  output logic sense_below_ref_out
);
  // -------
  // Inductor current decay and output droop.
  // -------
  logic [7:0] decay_q = 8'h00;
  logic [7:0] droop_q = 8'h00;
  logic [7:0] lim;
  assign lim = slow_in ? 8'h10 : 8'h08;
  // Current falls once the high-side switch opens; output droops only while both are off.
  always @(posedge clock_in) begin
    decay_q <= high_side_drive_in ? 8'h00 : decay_q + {7'h00, decay_q != 8'hFF};
    if (high_side_drive_in || low_side_drive_in) begin
      droop_q <= 8'h00;
    end else begin
      droop_q <= droop_q + {7'h00, droop_q != 8'hFF};
    end
  end
  assign zero_cross_out = decay_q >= lim;
  assign sense_below_ref_out = heavy_in || droop_q >= {lim[6:0], 1'b0};
endmodule
`default_nettype wire

// *** dv/tb_buck_fault_and_light_load_control.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_buck_fault_and_light_load_control;
  import bfl_pkg::*;
  // -------
  // Signals.
  // -------
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic oc = 1'b0, b95 = 1'b0, en = 1'b1, adc_v = 1'b0, ramp = 1'b0, allow_ll = 1'b0;
  logic trk = 1'b0, nvm_ld = 1'b0, slow = 1'b0, heavy = 1'b0;
  logic [2:0] tsel = 3'h3;
  logic [7:0] nom = 8'hC0, temp = 8'h19, comp = 8'h5A, ocmax = 8'h08, thr = 8'h7D;
  logic [10:0] vs = 11'h000;
  bfl_ocr_e ocr = OCR_CC;
  bfl_otr_e otr = OTR_INHIBIT;
  logic zc, sbr, hs, ls, pce, llm, hic, ocl, otf, calok, pg, ovw, uvf, uvw;
  logic [7:0] dl, dac, tr, vh, vl;
  int n_fail = 0, tests_run = 0, cyc = 0;

  bfl_ctrl #(.HICCUP_CYCLES(64)) i_dut (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .oc_cmp_in(oc), .zero_cross_in(zc),
    .sense_below_ref_in(sbr), .vout_below_95_in(b95), .enable_in(en),
    .target_select_pins_in(tsel), .nominal_duty_in(nom), .adc_valid_in(adc_v),
    .vsense_code_in(vs), .die_temp_code_in(temp), .comp_code_in(comp),
    .ref_ramping_in(ramp), .oc_response_in(ocr), .oc_max_count_in(ocmax),
    .allow_light_load_in(allow_ll), .tracking_mode_in(trk), .nvm_load_in(nvm_ld),
    .nvm_ot_thr_in(thr), .nvm_ot_resp_in(otr), .ov_warn_thr_in(11'h300),
    .uv_fault_thr_in(11'h040), .uv_warn_thr_in(11'h080), .target_table_in(88'h100 << 33),
    .pg_tol_in(11'h010), .high_side_drive_out(hs), .low_side_drive_out(ls),
    .power_conv_en_out(pce), .light_load_adaptive_mode_out(llm), .duty_limit_out(dl),
    .hiccup_out(hic), .oc_latched_out(ocl), .ot_fault_out(otf), .comp_dac_out(dac),
    .cal_done_out(calok), .die_temperature_reading_out(tr), .vout_reading_high_out(vh),
    .vout_reading_low_out(vl), .ov_warn_out(ovw), .uv_fault_out(uvf),
    .uv_warn_out(uvw), .power_good_out(pg)
  );
  bfl_stage_model i_stage (.clock_in(clock_in), .high_side_drive_in(hs),
    .low_side_drive_in(ls), .slow_in(slow), .heavy_in(heavy), .zero_cross_out(zc),
    .sense_below_ref_out(sbr));

  always #2 clock_in = ~clock_in;
  // -------
  // Shared tasks.
  // -------
  task automatic wrap_up();
    if (n_fail == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      wrap_up();
    end
  end
  task automatic tick(input int n = 1);
    repeat (n) begin
      @(posedge clock_in);
      #1;
    end
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rst();
    sys_rst_in = 1'b1;
    tick(4);
    sys_rst_in = 1'b0;
    tick(3);
  endtask
  task automatic adc(input logic [10:0] v, input logic [7:0] t);
    vs = v;
    temp = t;
    adc_v = 1'b1;
    tick();
    adc_v = 1'b0;
    tick(2);
  endtask
  task automatic do_cal();
    ramp = 1'b1;
    tick(4);
    ramp = 1'b0;
    tick(24);
    chk({calok, dac}, {1'b1, comp});
  endtask
  // -------
  // Scenarios.
  // -------
  task automatic t_vout();
    adc(11'h5A3, 8'h19);
    chk({vh, vl}, 16'h05A3);
    chk({ovw, uvf, uvw}, 3'b100);
    adc(11'h060, 8'h19);
    chk({ovw, uvf, uvw}, 3'b001);
    adc(11'h020, 8'h19);
    chk({ovw, uvf, uvw}, 3'b011);
  endtask
  task automatic t_ot(input bfl_otr_e r);
    rst();
    otr = r;
    if (r != OTR_INHIBIT) begin
      nvm_ld = 1'b1;
      tick();
      nvm_ld = 1'b0;
    end
    adc(11'h100, 8'h55);
    tick(2);
    chk({tr, pg, pce, otf}, {8'h55, 3'b110});
    adc(11'h200, 8'h55);
    chk({pg, otf}, 2'b10);
    adc(11'h200, 8'h56);
    tick(2);
    chk({pce, otf, pg}, (r == OTR_IGNORE) ? 3'b101 : 3'b010);
    if (r != OTR_IGNORE) chk({hs, ls}, 2'b00);
    adc(11'h200, 8'h3D);
    chk({pce, otf}, (r == OTR_IGNORE) ? 2'b10 : 2'b01);
    adc(11'h200, 8'h3C);
    chk({pce, otf}, (r == OTR_LATCH) ? 2'b01 : 2'b10);
  endtask
  task automatic t_fold();
    rst();
    ocr = OCR_CC;
    ocmax = 8'hFF;
    nom = 8'hC0;
    oc = 1'b1;
    tick(1024);
    oc = 1'b0;
    tick(300);
    chk(dl, 8'h80);
    tick(1536);
    chk(dl, 8'hC0);
    oc = 1'b1;
    tick(1800);
    oc = 1'b0;
    chk(dl, 8'h40);
    tick(1500);
    chk(dl, 8'h80);
    tick(1100);
    chk(dl, 8'hC0);
    nom = 8'h10;
    oc = 1'b1;
    tick(1024);
    oc = 1'b0;
    chk(dl, 8'h10);
    nom = 8'hC0;
    tick(2);
    chk(dl, 8'hC0);
  endtask
  task automatic t_oc_trip(input bfl_ocr_e r);
    int i;
    int w;
    rst();
    ocr = r;
    ocmax = 8'h08;
    nom = 8'hC0;
    oc = 1'b1;
    for (i = 0; i < 3600 && hic !== 1'b1 && ocl !== 1'b1; i++) tick();
    chk({hic, ocl, pce}, (r == OCR_LATCH) ? 3'b010 : 3'b100);
    for (w = 0; w < 200 && hic === 1'b1; w++) tick();
    chk(w[15:0] >> 2, (r == OCR_LATCH) ? 16'h0000 : 16'h0010);
    oc = 1'b0;
    tick(600);
    chk(ocl, r == OCR_LATCH);
  endtask
  task automatic t_refuse(input logic a, input logic t, input logic r);
    rst();
    nom = 8'h30;
    allow_ll = a;
    trk = t;
    do_cal();
    ramp = r;
    tick(3072);
    chk(llm, 1'b0);
    ramp = 1'b0;
    trk = 1'b0;
  endtask
  task automatic t_ll();
    int i;
    int w;
    rst();
    nom = 8'h30;
    allow_ll = 1'b1;
    slow = 1'b1;
    do_cal();
    tick(1536);
    chk(llm, 1'b0);
    for (i = 0; i < 1600 && llm !== 1'b1; i++) tick();
    chk(llm, 1'b1);
    for (i = 0; i < 600 && hs === 1'b1; i++) tick();
    for (i = 0; i < 600 && hs !== 1'b1; i++) tick();
    for (w = 0; w < 600 && hs === 1'b1; w++) tick();
    chk(w[15:0], 16'h0030);
    chk({hs, ls}, 2'b01);
    for (i = 0; i < 600 && ls === 1'b1; i++) tick();
    chk({hs, ls, i < 64}, 3'b001);
    heavy = 1'b1;
    for (i = 0; i < 2000 && llm === 1'b1; i++) tick();
    chk(llm, 1'b0);
    heavy = 1'b0;
    for (i = 0; i < 3600 && llm !== 1'b1; i++) tick();
    b95 = 1'b1;
    tick(5);
    chk({llm, i < 3600}, 2'b01);
    b95 = 1'b0;
  endtask
  // -------
  // Main sequence.
  // -------
  initial begin
    rst();
    t_vout();
    t_ot(OTR_INHIBIT);
    t_ot(OTR_IGNORE);
    t_ot(OTR_LATCH);
    t_fold();
    t_oc_trip(OCR_CC);
    t_oc_trip(OCR_HICCUP);
    t_oc_trip(OCR_LATCH);
    t_refuse(1'b0, 1'b0, 1'b0);
    t_refuse(1'b1, 1'b1, 1'b0);
    t_refuse(1'b1, 1'b0, 1'b1);
    t_ll();
    wrap_up();
  end
endmodule
`default_nettype wire

// *** logic/bfl_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "bfl_defs.svh"
module bfl_ctrl
  import bfl_pkg::*;
#(
  parameter int unsigned HICCUP_CYCLES = `BFL_HICCUP_MS * 1000 * `BFL_CLK_MHZ
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Power stage comparators and pins
  input wire logic oc_cmp_in,
  input wire logic zero_cross_in,
  input wire logic sense_below_ref_in,
  input wire logic vout_below_95_in,
  input wire logic enable_in,
  input wire logic [2:0] target_select_pins_in,
  // Regulation loop and converter
  input wire logic [7:0] nominal_duty_in,
  input wire logic adc_valid_in,
  input wire logic [10:0] vsense_code_in,
  input wire logic [7:0] die_temp_code_in,
  input wire logic [7:0] comp_code_in,
  input wire logic ref_ramping_in,
  // Configuration
  input wire bfl_ocr_e oc_response_in,
  input wire logic [7:0] oc_max_count_in,
  input wire logic allow_light_load_in,
  input wire logic tracking_mode_in,
  input wire logic nvm_load_in,
  input wire logic [7:0] nvm_ot_thr_in,
  input wire bfl_otr_e nvm_ot_resp_in,
  input wire logic [10:0] ov_warn_thr_in,
  input wire logic [10:0] uv_fault_thr_in,
  input wire logic [10:0] uv_warn_thr_in,
  input wire logic [87:0] target_table_in,
  input wire logic [10:0] pg_tol_in,
  // Drives and state
  output logic high_side_drive_out,
  output logic low_side_drive_out,
  output logic power_conv_en_out,
  output logic light_load_adaptive_mode_out,
  output logic [7:0] duty_limit_out,
  output logic hiccup_out,
  output logic oc_latched_out,
  output logic ot_fault_out,
  output logic [7:0] comp_dac_out,
  output logic cal_done_out,
  // Readings and flags
  output logic [7:0] die_temperature_reading_out,
  output logic [7:0] vout_reading_high_out,
  output logic [7:0] vout_reading_low_out,
  output logic ov_warn_out,
  output logic uv_fault_out,
  output logic uv_warn_out,
  output logic power_good_out
);
  logic [7:0] sync1_q, sync2_q;
  logic oc_s, zc_s, below_s, low95_s, en_s;
  logic [2:0] tsel_s;
  logic [7:0] sw_cnt_q;
  logic cyc_end, oc_seen_q, zc_seen_q, oc_cyc, zc_cyc;
  logic [1:0] level;
  logic [7:0] oc_total_q;
  logic oc_trip, hiccup_q, oc_latch_q;
  logic [31:0] hic_cnt_q;
  logic [7:0] ot_thr_q;
  bfl_otr_e ot_resp_q;
  logic ot_hot, ot_cool, ot_inh_q, ot_latch_q;
  logic fault, run;
  logic ramp_prev_q, cal_run_q;
  logic [7:0] cal_cnt_q;
  logic ll_ok;
  bfl_ll_e ll_q;
  logic [3:0] zc_run_q;
  logic [1:0] miss_q;
  logic [7:0] on_cnt_q, on_width_q;
  logic [10:0] vs_q, target;

  function automatic logic [8:0] to_celsius(input logic [7:0] code);
    to_celsius = {1'b0, code} + `BFL_TEMP_OFFSET;
  endfunction

  // ----------------------------------------
  // Pin synchronisers and switching cycle.
  // ----------------------------------------
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= {target_select_pins_in, enable_in, vout_below_95_in,
                  sense_below_ref_in, zero_cross_in, oc_cmp_in};
      sync2_q <= sync1_q;
    end
  end
  assign {tsel_s, en_s, low95_s, below_s, zc_s, oc_s} = sync2_q;

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sw_cnt_q <= 8'h00;
      oc_seen_q <= 1'b0;
      zc_seen_q <= 1'b0;
    end else begin
      sw_cnt_q <= sw_cnt_q + 8'h01;
      oc_seen_q <= cyc_end ? 1'b0 : (oc_seen_q | oc_s);
      zc_seen_q <= cyc_end ? 1'b0 : (zc_seen_q | zc_s);
    end
  end
  assign cyc_end = (sw_cnt_q == `BFL_SW_LAST);
  assign oc_cyc = oc_seen_q | oc_s;
  assign zc_cyc = zc_seen_q | zc_s;

  bfl_foldback u_fold (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .clear_in(!run),
    .cycle_in(cyc_end && ll_q == LL_PWM),
    .oc_in(oc_cyc),
    .cc_mode_in(oc_response_in == OCR_CC),
    .nominal_duty_in(nominal_duty_in),
    .limit_out(duty_limit_out),
    .level_out(level)
  );

  // ----------------------------------------
  // Overcurrent count, hiccup and latch.
  // ----------------------------------------
  assign oc_trip = run && cyc_end && oc_cyc && (oc_total_q + 8'h01 >= oc_max_count_in) &&
                   (oc_response_in != OCR_CC || level == `BFL_LVL_MAX ||
                    nominal_duty_in < `BFL_DUTY_EIGHTH);

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      oc_total_q <= 8'h00;
    end else if (!run) begin
      oc_total_q <= 8'h00;
    end else if (cyc_end && oc_cyc && oc_total_q != 8'hFF) begin
      oc_total_q <= oc_total_q + 8'h01;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hiccup_q <= 1'b0;
      hic_cnt_q <= 32'h0000_0000;
    end else if (oc_trip && oc_response_in != OCR_LATCH) begin
      hiccup_q <= 1'b1;
      hic_cnt_q <= 32'h0000_0000;
    end else if (hiccup_q) begin
      if (hic_cnt_q == 32'(HICCUP_CYCLES - 1)) begin
        hiccup_q <= 1'b0;
      end
      hic_cnt_q <= hic_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      oc_latch_q <= 1'b0;
    end else if (oc_trip && oc_response_in == OCR_LATCH) begin
      oc_latch_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Over-temperature.
  // ----------------------------------------
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ot_thr_q <= `BFL_OT_TRIP_DEF;
      ot_resp_q <= OTR_INHIBIT;
    end else if (nvm_load_in) begin
      ot_thr_q <= nvm_ot_thr_in;
      ot_resp_q <= nvm_ot_resp_in;
    end
  end

  assign ot_hot = to_celsius(die_temperature_reading_out) > {1'b0, ot_thr_q};
  assign ot_cool = to_celsius(die_temperature_reading_out) + `BFL_OT_HYST <=
                   {1'b0, ot_thr_q};

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ot_inh_q <= 1'b0;
      ot_latch_q <= 1'b0;
    end else begin
      if (ot_resp_q == OTR_INHIBIT && ot_hot) begin
        ot_inh_q <= 1'b1;
      end else if (ot_resp_q != OTR_INHIBIT || ot_cool) begin
        ot_inh_q <= 1'b0;
      end
      if (ot_resp_q == OTR_LATCH && ot_hot) begin
        ot_latch_q <= 1'b1;
      end
    end
  end

  assign fault = hiccup_q | oc_latch_q | ot_inh_q | ot_latch_q;
  assign run = en_s && !fault;

  // ----------------------------------------
  // Calibration of the error level.
  // ----------------------------------------
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ramp_prev_q <= 1'b0;
      cal_run_q <= 1'b0;
      cal_cnt_q <= 8'h00;
      cal_done_out <= 1'b0;
      comp_dac_out <= 8'h00;
    end else begin
      ramp_prev_q <= ref_ramping_in;
      if (ref_ramping_in) begin
        cal_done_out <= 1'b0;
        cal_run_q <= 1'b0;
      end else if (ramp_prev_q) begin
        cal_run_q <= 1'b1;
        cal_cnt_q <= 8'h00;
      end else if (cal_run_q) begin
        cal_cnt_q <= cal_cnt_q + 8'h01;
        if (cal_cnt_q == `BFL_CAL_DELAY) begin
          comp_dac_out <= comp_code_in;
          cal_done_out <= 1'b1;
          cal_run_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Light-load sequencer.
  // ----------------------------------------
  assign ll_ok = allow_light_load_in && !tracking_mode_in && !ref_ramping_in &&
                 cal_done_out && run && level == 2'h0;

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ll_q <= LL_PWM;
      zc_run_q <= 4'h0;
      miss_q <= 2'h0;
      on_cnt_q <= 8'h00;
      on_width_q <= 8'h00;
    end else if (!ll_ok || (ll_q != LL_PWM && low95_s)) begin
      ll_q <= LL_PWM;
      zc_run_q <= 4'h0;
      miss_q <= 2'h0;
    end else begin
      unique case (ll_q)
        LL_PWM: begin
          if (cyc_end) begin
            if (!zc_cyc) begin
              zc_run_q <= 4'h0;
            end else if (zc_run_q == `BFL_LL_ENTRY_RUN - 4'h1) begin
              ll_q <= LL_ON;
              zc_run_q <= 4'h0;
              on_cnt_q <= 8'h00;
              on_width_q <= duty_limit_out;
            end else begin
              zc_run_q <= zc_run_q + 4'h1;
            end
          end
        end
        LL_ON: begin
          on_cnt_q <= on_cnt_q + 8'h01;
          if (on_cnt_q + 8'h01 >= on_width_q) begin
            ll_q <= LL_DIODE;
          end
        end
        LL_DIODE: begin
          if (zc_s) begin
            ll_q <= LL_IDLE;
            if (!below_s) begin
              miss_q <= 2'h0;
            end else if (miss_q == `BFL_LL_EXIT_RUN - 2'h1) begin
              ll_q <= LL_PWM;
              miss_q <= 2'h0;
            end else begin
              miss_q <= miss_q + 2'h1;
            end
          end
        end
        LL_IDLE: begin
          if (below_s && zc_s) begin
            ll_q <= LL_ON;
            on_cnt_q <= 8'h00;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      high_side_drive_out <= 1'b0;
      low_side_drive_out <= 1'b0;
    end else if (!run) begin
      high_side_drive_out <= 1'b0;
      low_side_drive_out <= 1'b0;
    end else if (ll_q == LL_PWM) begin
      high_side_drive_out <= sw_cnt_q < duty_limit_out;
      low_side_drive_out <= !(sw_cnt_q < duty_limit_out);
    end else begin
      high_side_drive_out <= ll_q == LL_ON;
      low_side_drive_out <= ll_q == LL_DIODE;
    end
  end

  assign power_conv_en_out = run;
  assign light_load_adaptive_mode_out = ll_q != LL_PWM;
  assign hiccup_out = hiccup_q;
  assign oc_latched_out = oc_latch_q;
  assign ot_fault_out = ot_inh_q | ot_latch_q;

  // ----------------------------------------
  // Readings, thresholds and power good.
  // ----------------------------------------
  assign target = target_table_in[tsel_s * 11 +: 11];

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      vs_q <= 11'h000;
      die_temperature_reading_out <= 8'h00;
      ov_warn_out <= 1'b0;
      uv_fault_out <= 1'b0;
      uv_warn_out <= 1'b0;
    end else if (adc_valid_in) begin
      vs_q <= vsense_code_in;
      die_temperature_reading_out <= die_temp_code_in;
      ov_warn_out <= vsense_code_in > ov_warn_thr_in;
      uv_fault_out <= vsense_code_in < uv_fault_thr_in;
      uv_warn_out <= vsense_code_in < uv_warn_thr_in;
    end
  end
  assign vout_reading_high_out = {`BFL_VOUT_HI_PAD, vs_q[10:8]};
  assign vout_reading_low_out = vs_q[7:0];

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      power_good_out <= 1'b0;
    end else if (fault) begin
      power_good_out <= 1'b0;
    end else if (run && (vs_q > target ? vs_q - target : target - vs_q) <= pg_tol_in) begin
      power_good_out <= 1'b1;
    end
  end

  // ----------------------------------------
  // Checks.
  // ----------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  sequence hic_start_s;
    $rose(hiccup_q);
  endsequence
  sequence ll_enter_s;
    ll_q == LL_PWM ##1 ll_q == LL_ON;
  endsequence

  hiccup_hold_a: assert property (
    hic_start_s |-> !power_conv_en_out [*8])
    else $error("Conversion re-enabled early in hiccup.");
  ot_off_a: assert property (
    ot_inh_q |=> !high_side_drive_out && !low_side_drive_out)
    else $error("Switch on during over-temperature inhibit.");
  ll_entry_a: assert property (
    ll_enter_s |-> $past(zc_run_q) == 4'h7 && $past(cyc_end))
    else $error("Light-load entered without eight zero-cross cycles.");
  ll_exit_a: assert property (
    ll_q != LL_PWM && low95_s |=> ll_q == LL_PWM)
    else $error("Light-load not left on low output.");
  ll_gate_a: assert property (
    !ll_ok |=> ll_q == LL_PWM)
    else $error("Light-load active while not permitted.");
  idle_wait_a: assert property (
    (ll_q == LL_DIODE || ll_q == LL_IDLE) && below_s && !zc_s |=> ll_q != LL_ON)
    else $error("Pulse started before current reached zero.");
  pg_hold_a: assert property (
    power_good_out && !fault |=> power_good_out)
    else $error("Power good dropped without shutdown fault.");
  ot_reset_a: assert property (
    $fell(sys_rst_in) |-> ot_thr_q == `BFL_OT_TRIP_DEF)
    else $error("Trip threshold wrong after reset.");
endmodule
`default_nettype wire

// *** logic/bfl_defs.svh ***
`ifndef BFL_DEFS_SVH
`define BFL_DEFS_SVH
`define BFL_DUTY_HALF 8'h80
`define BFL_DUTY_QUARTER 8'h40
`define BFL_DUTY_EIGHTH 8'h20
`define BFL_DUTY_OPEN 8'hFF
`define BFL_FOLD_RUN 3'h3
`define BFL_RECOV_RUN 3'h4
`define BFL_LL_ENTRY_RUN 4'h8
`define BFL_LL_EXIT_RUN 2'h3
`define BFL_LVL_MAX 2'h3
`define BFL_SW_LAST 8'hFF
`define BFL_OC_MAX_DEF 8'h08
`define BFL_OT_TRIP_DEF 8'h7D
`define BFL_OT_HYST 9'h019
`define BFL_TEMP_OFFSET 9'h028
`define BFL_CAL_DELAY 8'h10
`define BFL_VOUT_HI_PAD 5'h00
`define BFL_HICCUP_MS 20
`define BFL_CLK_MHZ 250
`endif

// *** logic/bfl_foldback.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "bfl_defs.svh"
module bfl_foldback (
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Cycle events
  input wire logic clear_in,
  input wire logic cycle_in,
  input wire logic oc_in,
  input wire logic cc_mode_in,
  input wire logic [7:0] nominal_duty_in,
  // Clamp
  output logic [7:0] limit_out,
  output logic [1:0] level_out
);
  logic [1:0] level_q;
  logic [2:0] oc_run_q;
  logic [2:0] rec_run_q;

  function automatic logic [7:0] clamp_of(input logic [1:0] lvl);
    case (lvl)
      2'h1: clamp_of = `BFL_DUTY_HALF;
      2'h2: clamp_of = `BFL_DUTY_QUARTER;
      2'h3: clamp_of = `BFL_DUTY_EIGHTH;
      default: clamp_of = `BFL_DUTY_OPEN;
    endcase
  endfunction

  // ----------------------------------------
  // Fold-back and recovery sequencing.
  // ----------------------------------------
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      level_q <= 2'h0;
      oc_run_q <= 3'h0;
      rec_run_q <= 3'h0;
    end else if (clear_in) begin
      level_q <= 2'h0;
      oc_run_q <= 3'h0;
      rec_run_q <= 3'h0;
    end else if (cycle_in) begin
      if (oc_in) begin
        rec_run_q <= 3'h0;
        if (cc_mode_in && level_q != `BFL_LVL_MAX && nominal_duty_in >= `BFL_DUTY_EIGHTH) begin
          if (oc_run_q == `BFL_FOLD_RUN - 3'h1) begin
            level_q <= level_q + 2'h1;
            oc_run_q <= 3'h0;
          end else begin
            oc_run_q <= oc_run_q + 3'h1;
          end
        end
      end else begin
        oc_run_q <= 3'h0;
        if (level_q != 2'h0) begin
          if (rec_run_q == `BFL_RECOV_RUN - 3'h1) begin
            rec_run_q <= 3'h0;
            if (clamp_of(level_q - 2'h1) >= nominal_duty_in) begin
              level_q <= 2'h0;
            end else begin
              level_q <= level_q - 2'h1;
            end
          end else begin
            rec_run_q <= rec_run_q + 3'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      limit_out <= 8'h00;
    end else if (clamp_of(level_q) < nominal_duty_in) begin
      limit_out <= clamp_of(level_q);
    end else begin
      limit_out <= nominal_duty_in;
    end
  end

  assign level_out = level_q;

  // ----------------------------------------
  // Checks.
  // ----------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  sequence oc_third_s;
    cycle_in && oc_in && !clear_in && cc_mode_in && oc_run_q == 3'h2 &&
      level_q != `BFL_LVL_MAX && nominal_duty_in >= `BFL_DUTY_EIGHTH;
  endsequence

  fold_step_a: assert property (
    oc_third_s |=> level_q == $past(level_q) + 2'h1)
    else $error("Clamp did not step down after three overcurrent cycles.");
  recov_step_a: assert property (
    cycle_in && !oc_in && !clear_in && rec_run_q == 3'h3 && level_q != 2'h0
    |=> level_q < $past(level_q))
    else $error("Clamp did not relax after four clean cycles.");
  low_duty_a: assert property (
    cycle_in && level_q == 2'h0 && nominal_duty_in < `BFL_DUTY_EIGHTH |=> level_q == 2'h0)
    else $error("Clamp applied below one-eighth duty.");
  clamp_cap_a: assert property (
    $stable(nominal_duty_in) |=> limit_out <= $past(nominal_duty_in))
    else $error("Clamp rose above nominal duty.");
  run_break_a: assert property (
    cycle_in && !oc_in |=> oc_run_q == 3'h0)
    else $error("Overcurrent run not restarted.");
endmodule
`default_nettype wire

// *** logic/bfl_pkg.sv ***
package bfl_pkg;
  typedef enum logic [1:0] {
    LL_PWM = 2'b00,
    LL_ON = 2'b01,
    LL_DIODE = 2'b10,
    LL_IDLE = 2'b11
  } bfl_ll_e;
  typedef enum logic [1:0] {
    OCR_CC = 2'b00,
    OCR_HICCUP = 2'b01,
    OCR_LATCH = 2'b10
  } bfl_ocr_e;
  typedef enum logic [1:0] {
    OTR_IGNORE = 2'b00,
    OTR_INHIBIT = 2'b01,
    OTR_LATCH = 2'b10
  } bfl_otr_e;
endpackage
